// [logic/debug_reset_int_mask.sv]
// Debug-state control: reset and interrupt masking, break, step, HALT, connect.
// Assumes cores, memory fabric and debugger register port share sys_clk;
// only the reset pin is asynchronous.
//
// Overview of operation
// - Single stepping masks resets from the user system or program.
// - A debugger reset always resets the cores, mask or not.
// - After a debugger reset finishes, every core is put in break.
// - Resets raised under the mask wait pending and run once it lifts.
// - Break and single stepping mask interrupt requests.
// - Maskable, fast and float interrupts raised under the mask wait pending.
// - While running, debug logic leaves interrupts to the application.
// - Entering break takes the device out of HALT.
// - A stepped HALT does not halt; the step breaks at the next instruction.
// - Emulator start clears the boot source bit from 1 to 0.
// - Hot plug-in with the interface field not on low-pin debug fails.
// - After hot plug-in memory access is limited to RAM until a break or debugger reset.
// - Debugger accesses go through the same guards and error checks as software.
`timescale 1ns/100ps
module debug_reset_int_mask
   import dbg_pkg::*;
(
   input  wire logic                         sys_clk,
   input  wire logic                         nrst,
   // Register port
   input  wire logic [7:0]                   regAddr,
   input  wire logic [31:0]                  regWdata,
   input  wire logic                         regWrite,
   input  wire logic                         regRead,
   output logic [31:0]                       regRdata,
   // Reset sources
   input  wire logic                         pinResetReq,
   input  wire logic                         swResetReq,
   input  wire logic                         wdtResetReq,
   output logic                              coreReset,
   // Core control
   output logic [dbg_pkg::CORE_COUNT-1:0]    coreBreak,
   output logic                              stepGo,
   input  wire logic                         stepDone,
   input  wire logic                         haltReq,
   output logic                              haltMode,
   // Interrupt requests: maskable_int_request, fast_int_request, float_unit_int_request
   input  wire logic [dbg_pkg::INT_KINDS-1:0] intRequest,
   input  wire logic [dbg_pkg::INT_KINDS-1:0] intAck,
   output logic [dbg_pkg::INT_KINDS-1:0]     intDeliver,
   // Debugger memory access into the normal fabric
   output logic                              memReq,
   output logic                              memWrite,
   output logic [31:0]                       memAddr,
   output logic [31:0]                       memWdata,
   input  wire logic                         memDone,
   input  wire logic                         memErr,
   input  wire logic [31:0]                  memRdata,
   // Guard permit bits as software left them
   input  wire logic                         ram_guard_debug_permit,
   input  wire logic                         periph_guard_debug_permit,
   output logic                              irq
);

   // ********************
   // Declarations
   // ********************
   dbg_state_t              state_reg;
   logic                    pinMeta_reg, pinSync_reg, pinPrev_reg;
   logic                    rstMaskCfg_reg;
   logic                    bootSrcHi_reg, bootMatLo_reg;
   logic [1:0]              ifaceSel_reg;
   logic                    limited_reg;
   logic                    haltMode_reg, stepGo_reg, coreReset_reg;
   logic [CORE_COUNT-1:0]   coreBreak_reg;
   logic [7:0]              rstCnt_reg;
   logic                    dbgRstRun_reg;
   logic [31:0]             memAddr_reg, memData_reg;
   logic                    memReq_reg, memWrite_reg;
   logic [EV_COUNT-1:0]     irqStat_reg, irqMask_reg, events;
   logic [31:0]             regRdata_reg, rdValue;
   logic                    cmdWr, cmdBreak, cmdStep, cmdResume, cmdDbgRst;
   logic                    cmdEmuStart, cmdHotPlug, memGo, memRefused;
   logic                    stepRefused, resetBusy, userRstFire;

   req_hold_if #(.WIDTH(1))         rstHold ();
   req_hold_if #(.WIDTH(INT_KINDS)) intHold ();

   function automatic logic wrHit(input logic [7:0] ofs);
      wrHit = regWrite && (regAddr == ofs);
   endfunction : wrHit

   // ********************
   // Command decode
   // ********************
   assign cmdWr       = wrHit(OFS_CMD);
   assign cmdBreak    = cmdWr && regWdata[CMD_BREAK];
   assign cmdStep     = cmdWr && regWdata[CMD_STEP];
   assign cmdResume   = cmdWr && regWdata[CMD_RESUME];
   assign cmdDbgRst   = cmdWr && regWdata[CMD_DBGRST];
   assign cmdEmuStart = cmdWr && regWdata[CMD_EMUSTRT];
   assign cmdHotPlug  = cmdWr && regWdata[CMD_HOTPLUG];
   assign memGo       = wrHit(OFS_MEMCMD) && regWdata[MEM_GO] && !memReq_reg;
   // Limited mode only lets RAM through; stepping needs a break first
   assign memRefused  = memGo && limited_reg && !regWdata[MEM_RAM];
   assign stepRefused = cmdStep && (state_reg != ST_BREAK);

   // ********************
   // Reset pin synchroniser
   // ********************
   // The pin is only expected while running; the sync stage guards metastability anyway
   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         pinMeta_reg <= 1'b0;
         pinSync_reg <= 1'b0;
         pinPrev_reg <= 1'b0;
      end
      else
      begin
         pinMeta_reg <= pinResetReq;
         pinSync_reg <= pinMeta_reg;
         pinPrev_reg <= pinSync_reg;
      end
   end

   // ********************
   // Pending reset and interrupt holders
   // ********************
   assign resetBusy     = (rstCnt_reg != '0);
   assign userRstFire   = rstHold.deliver[0] && !resetBusy && !cmdDbgRst;
   assign rstHold.raise = {(pinSync_reg && !pinPrev_reg) || swResetReq || wdtResetReq};
   assign rstHold.ack   = {userRstFire};
   // Step always masks; break masks only while CTRL bit 0 is set, as it is after reset
   assign rstHold.mask  = (state_reg == ST_STEP) || (state_reg == ST_DBGRST)
                          || ((state_reg == ST_BREAK) && rstMaskCfg_reg);
   assign intHold.raise = intRequest;
   assign intHold.ack   = intAck;
   assign intHold.mask  = (state_reg != ST_RUN);
   assign intDeliver    = intHold.deliver;

   pending_hold rstKeep
   (
      .sys_clk (sys_clk),
      .nrst    (nrst),
      .hold    (rstHold.keeper)
   );

   pending_hold intKeep
   (
      .sys_clk (sys_clk),
      .nrst    (nrst),
      .hold    (intHold.keeper)
   );

   // ********************
   // Core reset pulse
   // ********************
   // The debugger reset bypasses the mask and restarts a running pulse
   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         rstCnt_reg    <= '0;
         coreReset_reg <= 1'b0;
         dbgRstRun_reg <= 1'b0;
      end
      else if (cmdDbgRst)
      begin
         rstCnt_reg    <= 8'(RST_CYCLES);
         coreReset_reg <= 1'b1;
         dbgRstRun_reg <= 1'b1;
      end
      else if (userRstFire)
      begin
         rstCnt_reg    <= 8'(RST_CYCLES);
         coreReset_reg <= 1'b1;
      end
      else if (resetBusy)
      begin
         rstCnt_reg    <= rstCnt_reg - 8'h01;
         coreReset_reg <= (rstCnt_reg != 8'h01);
         if (rstCnt_reg == 8'h01)
            dbgRstRun_reg <= 1'b0;
      end
   end

   // ********************
   // Debug state machine
   // ********************
   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
         state_reg <= ST_RUN;
      else if (cmdDbgRst)
         state_reg <= ST_DBGRST;
      else
         case (state_reg)
            ST_RUN:
               if (cmdBreak)
                  state_reg <= ST_BREAK;
            ST_BREAK:
               if (cmdStep)
                  state_reg <= ST_STEP;
               else if (cmdResume)
                  state_reg <= ST_RUN;
            ST_STEP:
               // A stepped HALT ends the step like any other instruction
               if (stepDone || haltReq)
                  state_reg <= ST_BREAK;
            ST_DBGRST:
               if (dbgRstRun_reg && rstCnt_reg == 8'h01)
                  state_reg <= ST_BREAK;
            default:
               state_reg <= ST_RUN;
         endcase
   end

   // ********************
   // Core outputs: break lines, step pulse, HALT
   // ********************
   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         coreBreak_reg <= '0;
         stepGo_reg    <= 1'b0;
         haltMode_reg  <= 1'b0;
      end
      else
      begin
         stepGo_reg <= (state_reg == ST_BREAK) && cmdStep && !cmdDbgRst;
         if (cmdDbgRst || (state_reg == ST_DBGRST))
            coreBreak_reg <= '1;
         else if (state_reg == ST_RUN && cmdBreak)
            coreBreak_reg <= '1;
         else if (state_reg == ST_BREAK && (cmdStep || cmdResume))
            coreBreak_reg <= '0;
         else if (state_reg == ST_STEP && (stepDone || haltReq))
            coreBreak_reg <= '1;
         if (cmdBreak || cmdDbgRst || state_reg != ST_RUN)
            haltMode_reg <= 1'b0;
         else if (haltReq)
            haltMode_reg <= 1'b1;
      end
   end

   // ********************
   // Option bits and connection mode
   // ********************
   // Hot plug-in leaves the program running with a reduced function set
   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         bootSrcHi_reg  <= BOOT_SRC_RST;
         bootMatLo_reg  <= BOOT_MAT_RST;
         ifaceSel_reg   <= IFACE_RST;
         rstMaskCfg_reg <= RST_MASK_RST;
         limited_reg    <= 1'b0;
      end
      else
      begin
         if (wrHit(OFS_CTRL))
            rstMaskCfg_reg <= regWdata[0];
         if (cmdEmuStart)
         begin
            bootSrcHi_reg <= 1'b0;
            ifaceSel_reg  <= IFACE_LPD;
         end
         else if (wrHit(OFS_OPTION))
         begin
            bootMatLo_reg <= regWdata[1];
            ifaceSel_reg  <= regWdata[3:2];
         end
         if (cmdBreak || cmdDbgRst)
            limited_reg <= 1'b0;
         else if (cmdHotPlug && ifaceSel_reg == IFACE_LPD)
            limited_reg <= 1'b1;
      end
   end

   // ********************
   // Debugger memory access
   // ********************
   // Plain master on the fabric, so guards and error checks apply unchanged
   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         memReq_reg   <= 1'b0;
         memWrite_reg <= 1'b0;
         memAddr_reg  <= '0;
         memData_reg  <= '0;
      end
      else
      begin
         if (wrHit(OFS_MEMADDR) && !memReq_reg)
            memAddr_reg <= regWdata;
         if (wrHit(OFS_MEMDATA) && !memReq_reg)
            memData_reg <= regWdata;
         if (memGo && !memRefused)
         begin
            memReq_reg   <= 1'b1;
            memWrite_reg <= regWdata[MEM_WRITE];
         end
         else if (memReq_reg && memDone)
         begin
            memReq_reg <= 1'b0;
            if (!memWrite_reg)
               memData_reg <= memRdata;
         end
      end
   end

   // ********************
   // Event status and interrupt
   // ********************
   assign events[EV_BREAK]   = (state_reg == ST_RUN && cmdBreak && !cmdDbgRst)
                               || (state_reg == ST_STEP && (stepDone || haltReq) && !cmdDbgRst);
   assign events[EV_STEP]    = state_reg == ST_STEP && stepDone && !cmdDbgRst;
   assign events[EV_DBGRST]  = dbgRstRun_reg && rstCnt_reg == 8'h01 && !cmdDbgRst;
   assign events[EV_CONNERR] = cmdHotPlug && ifaceSel_reg != IFACE_LPD;
   assign events[EV_REFUSED] = memRefused || stepRefused;
   assign events[EV_MEMERR]  = memReq_reg && memDone && memErr;

   // Set beats a simultaneous write-one clear
   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         irqStat_reg <= '0;
         irqMask_reg <= IRQMASK_RST;
      end
      else
      begin
         irqStat_reg <= (irqStat_reg & ~(wrHit(OFS_IRQSTAT) ? regWdata[EV_COUNT-1:0] : '0)) | events;
         if (wrHit(OFS_IRQMASK))
            irqMask_reg <= regWdata[EV_COUNT-1:0];
      end
   end

   // ********************
   // Register read
   // ********************
   always_comb
   begin
      rdValue = '0;
      case (regAddr)
         OFS_CTRL:    rdValue[0] = rstMaskCfg_reg;
         OFS_STATE:   rdValue[10:0] = {periph_guard_debug_permit, ram_guard_debug_permit, memReq_reg,
                                       intHold.held, rstHold.held[0], limited_reg, haltMode_reg, state_reg};
         OFS_OPTION:  rdValue[3:0] = {ifaceSel_reg, bootMatLo_reg, bootSrcHi_reg};
         OFS_MEMADDR: rdValue = memAddr_reg;
         OFS_MEMDATA: rdValue = memData_reg;
         OFS_IRQSTAT: rdValue[EV_COUNT-1:0] = irqStat_reg;
         OFS_IRQMASK: rdValue[EV_COUNT-1:0] = irqMask_reg;
         default:     rdValue = '0;           // Unmapped and write-only read zero
      endcase
   end

   // Data only in the cycle after the strobe
   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
         regRdata_reg <= '0;
      else
         regRdata_reg <= regRead ? rdValue : '0;
   end

   assign regRdata  = regRdata_reg;
   assign coreReset = coreReset_reg;
   assign coreBreak = coreBreak_reg;
   assign stepGo    = stepGo_reg;
   assign haltMode  = haltMode_reg;
   assign memReq    = memReq_reg;
   assign memWrite  = memWrite_reg;
   assign memAddr   = memAddr_reg;
   assign memWdata  = memData_reg;
   assign irq       = |(irqStat_reg & irqMask_reg);

endmodule : debug_reset_int_mask

// [logic/pending_hold.sv]
// Holds requests that arrive while a debug mask stands.
// Assumes raise and ack come from logic on the same clock.
`timescale 1ns/100ps
module pending_hold
(
   input  wire logic sys_clk,
   input  wire logic nrst,
   req_hold_if.keeper hold
);

   // ********************
   // Sticky request store
   // ********************
   // A raise in the same cycle as its ack survives, so no request is lost
   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
         hold.held <= '0;
      else
         hold.held <= (hold.held & ~hold.ack) | hold.raise;
   end

   // Nothing leaves while the mask stands
   assign hold.deliver = hold.mask ? '0 : hold.held;

endmodule : pending_hold

// [shared/dbg_pkg.sv]
// Constants shared by the debug reset and interrupt masking block.
// Assumes a 250 MHz system clock and a 32-bit plain register port.
package dbg_pkg;

   // ********************
   // Register offsets (byte addresses)
   // ********************
   localparam logic [7:0] OFS_CTRL    = 8'h00;
   localparam logic [7:0] OFS_CMD     = 8'h04;
   localparam logic [7:0] OFS_STATE   = 8'h08;
   localparam logic [7:0] OFS_OPTION  = 8'h0c;
   localparam logic [7:0] OFS_MEMADDR = 8'h10;
   localparam logic [7:0] OFS_MEMDATA = 8'h14;
   localparam logic [7:0] OFS_MEMCMD  = 8'h18;
   localparam logic [7:0] OFS_IRQSTAT = 8'h1c;
   localparam logic [7:0] OFS_IRQMASK = 8'h20;

   // ********************
   // Field positions
   // ********************
   localparam int CMD_BREAK   = 0;
   localparam int CMD_STEP    = 1;
   localparam int CMD_RESUME  = 2;
   localparam int CMD_DBGRST  = 3;
   localparam int CMD_EMUSTRT = 4;
   localparam int CMD_HOTPLUG = 5;
   localparam int MEM_GO      = 0;
   localparam int MEM_WRITE   = 1;
   localparam int MEM_RAM     = 2;
   localparam int EV_BREAK    = 0;
   localparam int EV_STEP     = 1;
   localparam int EV_DBGRST   = 2;
   localparam int EV_CONNERR  = 3;
   localparam int EV_REFUSED  = 4;
   localparam int EV_MEMERR   = 5;
   localparam int EV_COUNT    = 6;

   // ********************
   // Sizes, encodings and reset values
   // ********************
   localparam int         CORE_COUNT      = 2;
   localparam int         INT_KINDS       = 3;  // Maskable, fast, floating point
   localparam logic [1:0] IFACE_LPD       = 2'b01;
   localparam logic [1:0] IFACE_RST       = 2'b11;
   localparam logic       BOOT_SRC_RST    = 1'b1;
   localparam logic       BOOT_MAT_RST    = 1'b0;
   localparam logic       RST_MASK_RST    = 1'b1;
   localparam logic [EV_COUNT-1:0] IRQMASK_RST = '0;

   // ********************
   // Timing
   // ********************
   localparam int CLK_PERIOD_PS = 4000;
   localparam int RST_PULSE_NS  = 40;    // Length of a reset handed to the cores
   localparam int RST_CYCLES    = (RST_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

   typedef enum logic [1:0]
   {
      ST_RUN    = 2'b00,
      ST_BREAK  = 2'b01,
      ST_STEP   = 2'b10,
      ST_DBGRST = 2'b11
   } dbg_state_t;

endpackage : dbg_pkg

// [shared/req_hold_if.sv]
// Carrier between the control logic and a pending-request holder.
// Assumes both ends run on the same system clock.
`timescale 1ns/100ps
interface req_hold_if #(parameter int WIDTH = 1);
   logic [WIDTH-1:0] raise;    // New requests, one-cycle pulses
   logic [WIDTH-1:0] ack;      // Serviced requests, one-cycle pulses
   logic             mask;     // Debug mask in force
   logic [WIDTH-1:0] held;     // Requests waiting
   logic [WIDTH-1:0] deliver;  // Requests passed on

   modport owner (output raise, output ack, output mask, input held, input deliver);
   modport keeper (input raise, input ack, input mask, output held, output deliver);
endinterface : req_hold_if

// [sim/core_fabric_model.sv]
// Behavioural cores and memory fabric facing the debug control block.
// Assumes stepGo and memReq come from the block on sys_clk.
`timescale 1ns/100ps
module core_fabric_model
(
   input  wire logic        sys_clk,
   input  wire logic        stepGo,
   input  wire logic        memReq,
   input  wire logic [31:0] memAddr,
   input  wire logic [3:0]  lag,
   input  wire logic        haltStep,
   input  wire logic        haltPls,
   output logic             stepDone,
   output logic             haltReq,
   output logic             memDone,
   output logic             memErr,
   output logic [31:0]      memRdata
);
   logic       busy = 1'b0;
   logic       haltQ = 1'b0;
   logic [3:0] cnt = 4'h0;
   logic [3:0] mCnt = 4'h0;
   assign haltReq = haltQ | haltPls;
   // A step ends after lag cycles; a stepped HALT reports halt instead of done
   always_ff @(posedge sys_clk)
   begin
      stepDone <= 1'b0;
      haltQ    <= 1'b0;
      if (stepGo)
      begin
         busy <= 1'b1;
         cnt  <= lag;
      end
      else if (busy && cnt != 4'h0)
         cnt <= cnt - 4'h1;
      else if (busy)
      begin
         busy     <= 1'b0;
         stepDone <= !haltStep;
         haltQ    <= haltStep;
      end
   end
   // Memory answers after lag cycles; idle data toggles so stale values never match
   always_ff @(posedge sys_clk)
   begin
      mCnt     <= (memReq && !memDone) ? mCnt + 4'h1 : 4'h0;
      memDone  <= memReq && !memDone && mCnt == lag;
      memErr   <= memReq && !memDone && mCnt == lag && memAddr[31];
      memRdata <= (memReq && mCnt == lag) ? ~memAddr : ~memRdata;
   end
endmodule : core_fabric_model

// [sim/debug_reset_int_mask_checker.sv]
// Assertions on the ports of the debug reset and interrupt masking block.
// Assumes a bind to the top module, one clock, synchronous reset.
`timescale 1ns/100ps
module debug_reset_int_mask_checker
   import dbg_pkg::*;
(
   input wire logic                  sys_clk,
   input wire logic                  nrst,
   input wire logic [7:0]            regAddr,
   input wire logic [31:0]           regWdata,
   input wire logic                  regWrite,
   input wire logic                  coreReset,
   input wire logic [CORE_COUNT-1:0] coreBreak,
   input wire logic                  stepGo,
   input wire logic                  haltReq,
   input wire logic                  haltMode,
   input wire logic [INT_KINDS-1:0]  intDeliver,
   input wire logic                  memReq,
   input wire logic                  memDone,
   input wire logic [31:0]           memAddr
);
   logic [4:0] rstLen;
   logic       dbgCmd;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   // Debugger reset order seen on the register port
   assign dbgCmd = regWrite && regAddr == OFS_CMD && regWdata[CMD_DBGRST];
   // Cycles the core reset has stood high so far
   always_ff @(posedge sys_clk)
      if (!nrst || !coreReset)
         rstLen <= 5'h0;
      else
         rstLen <= rstLen + 5'h1;
   property p_dbgrst_now; dbgCmd |=> coreReset && &coreBreak; endproperty
   a_dbgrst_now: assert property (p_dbgrst_now) else $error("reset order ignored");
   property p_dbgrst_brk; dbgCmd |-> ##11 !coreReset && &coreBreak; endproperty
   a_dbgrst_brk: assert property (p_dbgrst_brk) else $error("no break after reset");
   property p_rst_len; $fell(coreReset) |-> rstLen == RST_CYCLES; endproperty
   a_rst_len: assert property (p_rst_len) else $error("reset pulse length");
   property p_int_brk; |coreBreak |-> intDeliver == '0; endproperty
   a_int_brk: assert property (p_int_brk) else $error("interrupt in break");
   property p_int_step; stepGo |-> intDeliver == '0; endproperty
   a_int_step: assert property (p_int_step) else $error("interrupt in step");
   property p_brk_nohalt; |coreBreak |-> !haltMode; endproperty
   a_brk_nohalt: assert property (p_brk_nohalt) else $error("halt kept in break");
   property p_step_halt; stepGo ##2 haltReq |=> &coreBreak && !haltMode; endproperty
   a_step_halt: assert property (p_step_halt) else $error("stepped halt halted");
   property p_mem_hold; memReq && !memDone |=> memReq && $stable(memAddr); endproperty
   a_mem_hold: assert property (p_mem_hold) else $error("memory request dropped");
endmodule : debug_reset_int_mask_checker
bind debug_reset_int_mask debug_reset_int_mask_checker u_chk (.*);

// [sim/debug_reset_int_mask_test.sv]
// Self-checking bench for the debug reset and interrupt masking block.
// Assumes the core and fabric model answers steps and memory requests.
`timescale 1ns/100ps
module debug_reset_int_mask_test;
   import dbg_pkg::*;
   logic                  sys_clk, nrst, regWrite, regRead, pinResetReq, swResetReq, wdtResetReq;
   logic                  stepDone, haltReq, haltMode, memReq, memWrite, memDone, memErr, irq;
   logic                  ramPermit, periphPermit, haltStep, haltPls, coreReset, stepGo;
   logic [CORE_COUNT-1:0] coreBreak;
   logic [2:0]            intRequest, intAck, intDeliver;
   logic [3:0]            lag;
   logic [7:0]            regAddr;
   logic [31:0]           regWdata, regRdata, memAddr, memWdata, memRdata, a, v;
   int                    fail_count, n_tests, seed, i, hi;
   debug_reset_int_mask u_dut
   (
      .*,
      .ram_guard_debug_permit    (ramPermit),
      .periph_guard_debug_permit (periphPermit)
   );
   core_fabric_model u_far (.*);
   // Expected status word: {rp, limited, halt} flags, pending interrupts
   function logic [31:0] stw(input logic [1:0] st, input logic [2:0] fl, input logic [2:0] ip);
      return {21'h0, periphPermit, ramPermit, 1'b0, ip, fl, st};
   endfunction : stw
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task results;
      if (fail_count == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : results
   task wr(input logic [7:0] ad, input logic [31:0] d);
      @(posedge sys_clk) {regAddr, regWdata, regWrite} <= {ad, d, 1'b1};
      @(posedge sys_clk) regWrite <= 1'b0;
   endtask : wr
   // Read data stands only in the cycle after the strobe
   task rdc(input logic [7:0] ad, input logic [31:0] m, input logic [31:0] e);
      @(posedge sys_clk) {regAddr, regRead} <= {ad, 1'b1};
      @(posedge sys_clk) regRead <= 1'b0;
      @(posedge sys_clk) chk(regRdata & m, e);
   endtask : rdc
   // Bounded wait for a level; one edge first so a stale level never ends it
   task waitFor(input int sel, input logic lvl);
      @(posedge sys_clk);
      for (i = 0; i < 40 && (sel ? memReq : sel < 0 ? &coreBreak : coreReset) !== lvl; i++)
         @(posedge sys_clk);
   endtask : waitFor
   initial
   begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   // Watchdog: the sequence needs well under a thousand cycles
   initial
   begin
      #40000;
      fail_count++;
      results;
   end
   initial
   begin
      seed = 32'h157e;
      {nrst, regWrite, regRead, swResetReq, wdtResetReq, haltStep, haltPls, intRequest, intAck} = '0;
      pinResetReq = 1'b0;
      {regAddr, regWdata, lag} = '0;
      {ramPermit, periphPermit} = 2'b11;
      repeat (8) @(posedge sys_clk);
      nrst <= 1'b1;
      rdc(OFS_CTRL, '1, 32'h1);
      rdc(OFS_OPTION, '1, 32'hd);
      rdc(8'h24, '1, 32'h0);
      rdc(OFS_STATE, '1, stw(2'h0, 3'h0, 3'h0));
      // Running: random interrupts pass straight through
      repeat (3)
      begin
         v = $random(seed) | 32'h1;
         @(posedge sys_clk) intRequest <= v[2:0];
         @(posedge sys_clk) intRequest <= 3'h0;
         @(posedge sys_clk) chk(32'(intDeliver), v & 32'h7);
         intAck <= 3'h7;
         @(posedge sys_clk) intAck <= 3'h0;
      end
      // Break: interrupts and a user reset wait, the latter until CTRL drops the mask
      wr(OFS_CMD, 32'h1);
      @(posedge sys_clk) intRequest <= 3'h7;
      @(posedge sys_clk) intRequest <= 3'h0;
      @(posedge sys_clk) swResetReq <= 1'b1;
      @(posedge sys_clk) swResetReq <= 1'b0;
      rdc(OFS_STATE, '1, stw(2'h1, 3'h4, 3'h7));
      chk(32'(coreReset), 32'h0);
      wr(OFS_CTRL, 32'h0);
      waitFor(0, 1'b1);
      chk(32'(coreReset), 32'h1);
      wr(OFS_CTRL, 32'h1);
      // Slow step: a watchdog reset waits until the device runs again
      lag <= 4'h8 | 4'($random(seed));
      wr(OFS_CMD, 32'h2);
      @(posedge sys_clk) wdtResetReq <= 1'b1;
      @(posedge sys_clk) wdtResetReq <= 1'b0;
      rdc(OFS_STATE, '1, stw(2'h2, 3'h4, 3'h7));
      waitFor(-1, 1'b1);
      chk(32'(coreReset), 32'h0);
      wr(OFS_CMD, 32'h4);
      @(posedge sys_clk) chk(32'(intDeliver), 32'h7);
      intAck <= 3'h7;
      waitFor(0, 1'b1);
      chk(32'(coreReset), 32'h1);
      intAck <= 3'h0;
      waitFor(0, 1'b0);
      // HALT left on break; a stepped HALT breaks instead of halting
      lag <= 4'h0;
      @(posedge sys_clk) haltPls <= 1'b1;
      @(posedge sys_clk) haltPls <= 1'b0;
      @(posedge sys_clk) chk(32'(haltMode), 32'h1);
      wr(OFS_CMD, 32'h1);
      @(posedge sys_clk) chk(32'(haltMode), 32'h0);
      haltStep <= 1'b1;
      wr(OFS_CMD, 32'h2);
      waitFor(-1, 1'b1);
      rdc(OFS_STATE, '1, stw(2'h1, 3'h0, 3'h0));
      haltStep <= 1'b0;
      // Debugger reset: a fixed-length pulse, then break and its status bit
      wr(OFS_CMD, 32'h8);
      hi = 0;
      repeat (12) @(posedge sys_clk) hi += coreReset;
      chk(32'(hi), 32'(RST_CYCLES));
      rdc(OFS_IRQSTAT, 32'h4, 32'h4);
      // Hot plug refused on the shipped interface, accepted after emulator start
      wr(OFS_CMD, 32'h20);
      rdc(OFS_IRQSTAT, 32'h8, 32'h8);
      wr(OFS_CMD, 32'h10);
      rdc(OFS_OPTION, '1, 32'h4);
      wr(OFS_CMD, 32'h4);
      wr(OFS_CMD, 32'h20);
      rdc(OFS_STATE, '1, stw(2'h0, 3'h2, 3'h0));
      a = $random(seed) & 32'h7fff_fffc;
      wr(OFS_MEMADDR, a);
      wr(OFS_MEMCMD, 32'h1);
      @(posedge sys_clk) chk(32'(memReq), 32'h0);
      rdc(OFS_IRQSTAT, 32'h10, 32'h10);
      wr(OFS_MEMCMD, 32'h5);
      @(posedge sys_clk) chk(32'(memReq), 32'h1);
      waitFor(1, 1'b0);
      rdc(OFS_MEMDATA, '1, ~a);
      wr(OFS_MEMDATA, a);
      wr(OFS_MEMCMD, 32'h7);
      @(posedge sys_clk) chk({memWdata[31:1], memWrite}, a | 32'h1);
      waitFor(1, 1'b0);
      wr(OFS_MEMADDR, a | 32'h8000_0000);
      wr(OFS_MEMCMD, 32'h5);
      waitFor(1, 1'b0);
      rdc(OFS_IRQSTAT, 32'h20, 32'h20);
      // Interrupt output: masked, raised, cleared by writing one
      chk(32'(irq), 32'h0);
      wr(OFS_IRQMASK, 32'h20);
      @(posedge sys_clk) chk(32'(irq), 32'h1);
      wr(OFS_IRQSTAT, 32'h3f);
      @(posedge sys_clk) chk(32'(irq), 32'h0);
      wr(OFS_CMD, 32'h1);
      rdc(OFS_STATE, 32'h8, 32'h0);
      // Pin reset only while running
      wr(OFS_CMD, 32'h4);
      @(posedge sys_clk) pinResetReq <= 1'b1;
      waitFor(0, 1'b1);
      chk(32'(coreReset), 32'h1);
      pinResetReq <= 1'b0;
      waitFor(0, 1'b0);
      results;
   end
endmodule : debug_reset_int_mask_test
